/* hdl/cbi_pkg.sv */
// Constants, register map and state encoding of the CAN integration core.
// Assumes one 250 MHz clock and an Avalon-MM slave port for software.
package cbi_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_TIMING = 6'h04;
	localparam logic [5:0] OFS_STATUS = 6'h08;
	localparam logic [5:0] OFS_IRQ_STAT = 6'h0C;
	localparam logic [5:0] OFS_IRQ_MASK = 6'h10;
	localparam logic [5:0] OFS_TX_REQ = 6'h14;
	localparam logic [5:0] OFS_TX_ID = 6'h18;
	localparam logic [5:0] OFS_TX_DATA = 6'h1C;
	localparam logic [5:0] OFS_RX_ID = 6'h20;
	localparam logic [5:0] OFS_RX_DATA = 6'h24;

	// Field positions of core_control_register, nominal_bit_timing_register and the TX ID register
	localparam int CTRL_HALT_BIT = 0;
	localparam int CTRL_EFEN_BIT = 1;
	localparam int CTRL_PXHD_BIT = 2;
	localparam int TIM_BRP_LSB = 0;
	localparam int TIM_SEG1_LSB = 8;
	localparam int TIM_SEG2_LSB = 16;
	localparam int TXID_FDF_BIT = 11;
	localparam int TXID_DLC_LSB = 12;

	// Writable masks and reset values
	localparam logic [31:0] CTRL_RW = 32'h0000_0007;
	localparam logic [31:0] TIMING_RW = 32'h007F_FFFF;
	localparam logic [31:0] TXID_RW = 32'h0000_FFFF;
	localparam logic [31:0] IRQ_RW = 32'h0000_003F;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam logic [31:0] TIMING_RESET = 32'h0003_0B03;

	// Interrupt status bits
	localparam int IRQ_INTEG = 0;
	localparam int IRQ_RX = 1;
	localparam int IRQ_TX = 2;
	localparam int IRQ_CRC = 3;
	localparam int IRQ_PXE = 4;
	localparam int IRQ_ERR = 5;
	localparam int IRQ_W = 6;

	// Frame layout and bit counts
	localparam logic [3:0] INTEG_LAST = 4'hA;
	localparam logic [3:0] ERR_FLAG_BITS = 4'h6;
	localparam logic [3:0] ERR_END = 4'hD;
	localparam logic [3:0] INTER_LAST = 4'h2;
	localparam logic [2:0] STUFF_LIMIT = 3'h5;
	localparam logic [7:0] ID_BITS = 8'h0B;
	localparam logic [7:0] FDF_POS = 8'h0B;
	localparam logic [7:0] RES_POS = 8'h0C;
	localparam logic [7:0] DATA_LO = 8'h11;
	localparam logic [7:0] ACK_OFS = 8'h01;
	localparam logic [7:0] EOF_OFS = 8'h09;
	localparam logic [3:0] DLC_MAX = 4'h4;
	localparam logic [4:0] CRC15_LEN = 5'h0F;
	localparam logic [4:0] CRC17_LEN = 5'h11;

	// CRC polynomials and start values
	localparam logic [14:0] CRC15_POLY = 15'h4599;
	localparam logic [16:0] CRC17_POLY = 17'h1_685B;
	localparam logic [14:0] CRC15_INIT = 15'h0000;
	localparam logic [16:0] CRC17_INIT = 17'h1_0000;

	// Protocol states, one-hot
	typedef enum logic [5:0] {
		ST_HALT = 6'h01,
		ST_INTEG = 6'h02,
		ST_IDLE = 6'h04,
		ST_FRAME = 6'h08,
		ST_ERROR = 6'h10,
		ST_INTER = 6'h20
	} cbi_state_t;

endpackage

/* hdl/cbi_crc.sv */
// Classical CRC-15 and FD CRC-17 generators, shifted one bit at a time.
// Assumes the caller pulses init_i at each start of frame.
module cbi_crc import cbi_pkg::*; (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic init_i,
	input wire logic shift_i,
	input wire logic bit_i,
	output logic [14:0] crc15_o,
	output logic [16:0] crc17_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Feedback terms
	wire logic fb15 = bit_i ^ crc15_o[14];
	wire logic fb17 = bit_i ^ crc17_o[16];
	wire logic [14:0] next_crc15 = {crc15_o[13:0], 1'b0} ^ (fb15 ? CRC15_POLY : 15'h0000);
	wire logic [16:0] next_crc17 = {crc17_o[15:0], 1'b0} ^ (fb17 ? CRC17_POLY : 17'h0_0000);

	// Both registers restart at every frame start
	always_ff @(posedge clock_i)
	begin
		if (reset_i || init_i)
		begin
			crc15_o <= CRC15_INIT;
			crc17_o <= CRC17_INIT;
		end
		else if (shift_i)
		begin
			crc15_o <= next_crc15;
			crc17_o <= next_crc17;
		end
	end

endmodule // cbi_crc

/* hdl/cbi_can_integ.sv */
// CAN protocol core: bus integration with optional edge filter, frame engine,
// error frames, intermission and an Avalon-MM register slave.
// Assumes can_rx_i is synchronous to clock_i; software programs the timing.
module cbi_can_integ import cbi_pkg::*; (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic [5:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic can_rx_i,
	output logic can_tx_o,
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Byte-lane merge of a write into a register
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be, input logic [31:0] rw);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & rw;
		return (old & ~m) | (wd & m);
	endfunction

	cbi_state_t st;
	logic [31:0] ctrl_q, timing_q, txid_q, txdata_q, mask_q;
	logic [IRQ_W-1:0] irq_stat, ev;
	logic tx_req, tx_active, rx_prev, rx_filt, dom_prev, last_bit, rx_fdf;
	logic [7:0] brp_cnt, fcnt;
	logic [8:0] tq_cnt;
	logic [3:0] cnt, rx_dlc;
	logic [2:0] same_cnt;
	logic [10:0] rx_id_sh, rx_id_q;
	logic [31:0] rx_data_sh, rx_data_q;
	logic [16:0] crc_rx;
	logic [14:0] crc15;
	logic [16:0] crc17;

	////////////////////////////////////////////////////////////////////////////////
	// Control fields
	wire logic halt = ctrl_q[CTRL_HALT_BIT];
	wire logic efen = ctrl_q[CTRL_EFEN_BIT];
	wire logic pxhd = ctrl_q[CTRL_PXHD_BIT];
	wire logic [7:0] brp = timing_q[TIM_BRP_LSB +: 8];
	wire logic [7:0] seg1 = timing_q[TIM_SEG1_LSB +: 8];
	wire logic [6:0] seg2 = timing_q[TIM_SEG2_LSB +: 7];
	wire logic [10:0] tx_id = txid_q[10:0];
	wire logic tx_fdf = txid_q[TXID_FDF_BIT];
	wire logic [3:0] tx_dlc = txid_q[TXID_DLC_LSB +: 4];

	// Time quanta and bit segmentation; segment 2 lasts field plus one quanta
	wire logic tq_tick = brp_cnt == brp;
	wire logic [8:0] bit_last = 9'(seg1) + 9'(seg2) + 9'd1;
	wire logic sample_pt = tq_tick && tq_cnt == 9'(seg1);
	wire logic bit_end = tq_tick && tq_cnt == bit_last;

	// Edge filter only while integrating, observed level feeds all timing
	wire logic filter_on = efen && st == ST_INTEG;
	wire logic rx_obs = filter_on ? rx_filt : can_rx_i;
	wire logic idle_like = st == ST_IDLE || st == ST_INTEG || st == ST_INTER;
	wire logic hard_sync = rx_prev && !rx_obs && idle_like && !tx_active;

	// Frame layout from the received control field
	wire logic [3:0] dlc_eff = rx_dlc > DLC_MAX ? DLC_MAX : rx_dlc;
	wire logic [7:0] data_end = DATA_LO + {1'b0, dlc_eff, 3'b000};
	wire logic [4:0] crc_len = rx_fdf ? CRC17_LEN : CRC15_LEN;
	wire logic [7:0] crc_end = data_end + 8'(crc_len);
	wire logic [7:0] ack_pos = crc_end + ACK_OFS;
	wire logic [7:0] eof_last = crc_end + EOF_OFS;
	wire logic [7:0] data_idx = fcnt - DATA_LO;
	wire logic [7:0] crc_idx = fcnt - data_end;
	wire logic [16:0] crc_calc = rx_fdf ? crc17 : {2'b00, crc15};
	wire logic [16:0] crc_got = rx_fdf ? crc_rx : {2'b00, crc_rx[14:0]};
	wire logic crc_match = crc_calc == crc_got;

	// Stuffing, arbitration and bit checks
	wire logic is_stuff = fcnt < crc_end && same_cnt == STUFF_LIMIT;
	wire logic stuff_err = is_stuff && rx_obs == last_bit;
	wire logic arb_lost = tx_active && !is_stuff && fcnt < ID_BITS && can_tx_o && !rx_obs;
	wire logic bit_err = tx_active && rx_obs != can_tx_o && !arb_lost && fcnt != ack_pos;

	// Bit our transmitter sends at frame position fcnt
	wire logic tx_field_bit = fcnt < ID_BITS ? tx_id[4'd10 - fcnt[3:0]] :
		fcnt == FDF_POS ? tx_fdf :
		fcnt == RES_POS ? 1'b0 :
		fcnt < DATA_LO ? tx_dlc[2'(8'd16 - fcnt)] :
		fcnt < data_end ? txdata_q[5'(8'd31 - data_idx)] :
		fcnt < crc_end ? crc_calc[5'(8'(crc_len) - 8'd1 - crc_idx)] : 1'b1;

	// Start of frame seen at idle or at the third intermission bit
	wire logic frame_start = !halt && sample_pt && !rx_obs &&
		(st == ST_IDLE || (st == ST_INTER && cnt == INTER_LAST));
	wire logic crc_shift = st == ST_FRAME && sample_pt && !is_stuff && fcnt < data_end;

	cbi_crc u_crc (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.init_i(frame_start),
		.shift_i(crc_shift),
		.bit_i(rx_obs),
		.crc15_o(crc15),
		.crc17_o(crc17)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Prescaler and quantum counter with hard synchronisation
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			brp_cnt <= 8'h00;
			tq_cnt <= 9'h000;
		end
		else if (hard_sync)
		begin
			brp_cnt <= 8'h00;
			tq_cnt <= 9'h001;
		end
		else if (tq_tick)
		begin
			brp_cnt <= 8'h00;
			tq_cnt <= bit_end ? 9'h000 : tq_cnt + 9'h001;
		end
		else
			brp_cnt <= brp_cnt + 8'h01;
	end

	// Edge filter: dominant only after two dominant quanta in a row
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			dom_prev <= 1'b0;
			rx_filt <= 1'b1;
			rx_prev <= 1'b1;
		end
		else
		begin
			rx_prev <= rx_obs;
			if (tq_tick)
			begin
				dom_prev <= !can_rx_i;
				rx_filt <= !(dom_prev && !can_rx_i);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Protocol state machine
	always_ff @(posedge clock_i)
	begin
		ev <= '0;
		if (reset_i)
		begin
			st <= ST_HALT;
			cnt <= 4'h0;
			fcnt <= 8'h00;
			same_cnt <= 3'h0;
			last_bit <= 1'b1;
			tx_active <= 1'b0;
			can_tx_o <= 1'b1;
			rx_fdf <= 1'b0;
			rx_dlc <= 4'h0;
			rx_id_sh <= 11'h000;
			rx_data_sh <= 32'h0000_0000;
			crc_rx <= 17'h0_0000;
			rx_id_q <= 11'h000;
			rx_data_q <= 32'h0000_0000;
		end
		else if (halt)
		begin
			st <= ST_HALT;
			tx_active <= 1'b0;
			can_tx_o <= 1'b1;
		end
		else if (frame_start)
		begin
			st <= ST_FRAME;
			tx_active <= tx_req;
			fcnt <= 8'h00;
			same_cnt <= 3'h1;
			last_bit <= 1'b0;
			rx_fdf <= 1'b0;
			rx_dlc <= 4'h0;
		end
		else
		begin
			case (st)
				ST_HALT:
				begin
					st <= ST_INTEG;
					cnt <= 4'h0;
				end
				ST_INTEG:
				if (sample_pt)
				begin
					if (!rx_obs)
						cnt <= 4'h0;
					else if (cnt == INTEG_LAST)
					begin
						st <= ST_IDLE;
						ev[IRQ_INTEG] <= 1'b1;
					end
					else
						cnt <= cnt + 4'h1;
				end
				ST_IDLE:
				if (bit_end)
				begin
					can_tx_o <= !tx_req;
					tx_active <= tx_req;
				end
				ST_INTER:
				if (sample_pt)
				begin
					if (!rx_obs)
						cnt <= 4'h0;
					else if (cnt == INTER_LAST)
						st <= ST_IDLE;
					else
						cnt <= cnt + 4'h1;
				end
				else if (bit_end)
					can_tx_o <= 1'b1;
				ST_ERROR:
				if (sample_pt)
				begin
					if (cnt < ERR_FLAG_BITS)
						cnt <= cnt + 4'h1;
					else if (!rx_obs)
						cnt <= ERR_FLAG_BITS;
					else if (cnt == ERR_END)
					begin
						st <= ST_INTER;
						cnt <= 4'h0;
					end
					else
						cnt <= cnt + 4'h1;
				end
				else if (bit_end)
					can_tx_o <= cnt >= ERR_FLAG_BITS;
				ST_FRAME:
				if (sample_pt)
				begin
					if (stuff_err || bit_err)
					begin
						st <= ST_ERROR;
						cnt <= 4'h0;
						tx_active <= 1'b0;
						ev[IRQ_ERR] <= 1'b1;
					end
					else if (is_stuff)
					begin
						same_cnt <= 3'h1;
						last_bit <= rx_obs;
					end
					else
					begin
						same_cnt <= rx_obs == last_bit ? same_cnt + 3'h1 : 3'h1;
						last_bit <= rx_obs;
						fcnt <= fcnt + 8'h01;
						if (arb_lost)
							tx_active <= 1'b0;
						if (fcnt < ID_BITS)
							rx_id_sh <= {rx_id_sh[9:0], rx_obs};
						if (fcnt == FDF_POS)
							rx_fdf <= rx_obs;
						if (fcnt > RES_POS && fcnt < DATA_LO)
							rx_dlc <= {rx_dlc[2:0], rx_obs};
						if (fcnt >= DATA_LO && fcnt < data_end)
							rx_data_sh <= {rx_data_sh[30:0], rx_obs};
						if (fcnt >= data_end && fcnt < crc_end)
							crc_rx <= {crc_rx[15:0], rx_obs};
						if (fcnt == RES_POS && rx_fdf && rx_obs)
						begin
							ev[IRQ_PXE] <= 1'b1;
							tx_active <= 1'b0;
							st <= pxhd ? ST_ERROR : ST_INTEG;
							cnt <= 4'h0;
						end
						if (fcnt == crc_end && !crc_match)
						begin
							st <= ST_ERROR;
							cnt <= 4'h0;
							tx_active <= 1'b0;
							ev[IRQ_CRC] <= 1'b1;
						end
						if (fcnt == ack_pos && tx_active && rx_obs)
						begin
							st <= ST_ERROR;
							cnt <= 4'h0;
							tx_active <= 1'b0;
							ev[IRQ_ERR] <= 1'b1;
						end
						if (fcnt == eof_last)
						begin
							st <= ST_INTER;
							cnt <= 4'h0;
							tx_active <= 1'b0;
							ev[IRQ_TX] <= tx_active;
							ev[IRQ_RX] <= !tx_active;
							rx_id_q <= rx_id_sh;
							rx_data_q <= rx_data_sh;
						end
					end
				end
				else if (bit_end)
					can_tx_o <= tx_active ? (is_stuff ? !last_bit : tx_field_bit) :
						fcnt != ack_pos;
				default:
					st <= ST_HALT;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode and read data
	wire logic wr_take = avs_write_i && !avs_waitrequest_o;
	wire logic [31:0] status_word = {20'h0_0000, 1'b0, tx_req, tx_active, rx_obs, 2'b00, st};
	wire logic [31:0] rd_mux =
		avs_address_i == OFS_CTRL ? ctrl_q :
		avs_address_i == OFS_TIMING ? timing_q :
		avs_address_i == OFS_STATUS ? status_word :
		avs_address_i == OFS_IRQ_STAT ? 32'(irq_stat) :
		avs_address_i == OFS_IRQ_MASK ? mask_q :
		avs_address_i == OFS_TX_REQ ? 32'(tx_req) :
		avs_address_i == OFS_TX_ID ? txid_q :
		avs_address_i == OFS_TX_DATA ? txdata_q :
		avs_address_i == OFS_RX_ID ? {20'h0_0000, rx_fdf, rx_id_q} :
		avs_address_i == OFS_RX_DATA ? rx_data_q : 32'h0000_0000;
	wire logic [31:0] w1 = merge(32'h0000_0000, avs_writedata_i, avs_byteenable_i, IRQ_RW);
	wire logic sw_tx_set = wr_take && avs_address_i == OFS_TX_REQ && w1[0];
	wire logic [IRQ_W-1:0] irq_clr = wr_take && avs_address_i == OFS_IRQ_STAT ?
		w1[IRQ_W-1:0] : '0;

	// One wait state per access, read data registered with the answer
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h0000_0000;
		end
		else
		begin
			avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
			if (avs_read_i && avs_waitrequest_o)
				avs_readdata_o <= rd_mux;
		end
	end

	// Software registers; hardware set wins over software clear
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			ctrl_q <= CTRL_RESET;
			timing_q <= TIMING_RESET;
			txid_q <= 32'h0000_0000;
			txdata_q <= 32'h0000_0000;
			mask_q <= 32'h0000_0000;
			irq_stat <= '0;
			tx_req <= 1'b0;
			irq_o <= 1'b0;
		end
		else
		begin
			if (wr_take && avs_address_i == OFS_CTRL)
				ctrl_q <= merge(ctrl_q, avs_writedata_i, avs_byteenable_i, CTRL_RW);
			if (wr_take && avs_address_i == OFS_TIMING)
				timing_q <= merge(timing_q, avs_writedata_i, avs_byteenable_i, TIMING_RW);
			if (wr_take && avs_address_i == OFS_TX_ID)
				txid_q <= merge(txid_q, avs_writedata_i, avs_byteenable_i, TXID_RW);
			if (wr_take && avs_address_i == OFS_TX_DATA)
				txdata_q <= merge(txdata_q, avs_writedata_i, avs_byteenable_i, 32'hFFFF_FFFF);
			if (wr_take && avs_address_i == OFS_IRQ_MASK)
				mask_q <= merge(mask_q, avs_writedata_i, avs_byteenable_i, IRQ_RW);
			irq_stat <= (irq_stat & ~irq_clr) | ev;
			tx_req <= (tx_req && !ev[IRQ_TX]) || sw_tx_set;
			irq_o <= |(irq_stat & mask_q[IRQ_W-1:0]);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (reset_i);

	property p_integ_end;
		st == ST_INTEG && sample_pt && rx_obs && cnt == INTEG_LAST && !halt |=> st == ST_IDLE;
	endproperty
	a_integ_end: assert property (p_integ_end) else $error("integration did not end");
	property p_filter_off;
		st != ST_INTEG |-> !filter_on;
	endproperty
	a_filter_off: assert property (p_filter_off) else $error("filter outside integration");
	property p_spike;
		filter_on && tq_tick && !dom_prev |=> rx_filt;
	endproperty
	a_spike: assert property (p_spike) else $error("single quantum spike passed");
	property p_obs;
		filter_on |-> rx_obs == rx_filt;
	endproperty
	a_obs: assert property (p_obs) else $error("timing not on filtered input");
	property p_halt;
		halt |=> st == ST_HALT && can_tx_o;
	endproperty
	a_halt: assert property (p_halt) else $error("halted core on bus");
	property p_enter_integ;
		st == ST_HALT && !halt |=> st == ST_INTEG && cnt == 4'h0;
	endproperty
	a_enter_integ: assert property (p_enter_integ) else $error("no integration after halt");
	property p_crc_err;
		st == ST_FRAME && sample_pt && !is_stuff && !stuff_err && !bit_err &&
			fcnt == crc_end && !crc_match && !halt |=> st == ST_ERROR ##[1:1000] !can_tx_o;
	endproperty
	a_crc_err: assert property (p_crc_err) else $error("no error frame on crc mismatch");
	property p_crc_init;
		frame_start |=> crc15 == CRC15_INIT && crc17 == CRC17_INIT;
	endproperty
	a_crc_init: assert property (p_crc_init) else $error("crc not reset at frame start");
	property p_inter_sof;
		st == ST_INTER && sample_pt && cnt == INTER_LAST && !rx_obs && tx_req && !halt
			|=> st == ST_FRAME && tx_active && fcnt == 8'h00;
	endproperty
	a_inter_sof: assert property (p_inter_sof) else $error("pending frame not started");
	property p_seg2;
		sample_pt |=> !sample_pt [*2];
	endproperty
	a_seg2: assert property (p_seg2) else $error("two samples in one bit");

	c_integ_done: cover property (st == ST_INTEG ##1 st == ST_IDLE);
	c_rx_ok: cover property (ev[IRQ_RX]);
	c_tx_ok: cover property (ev[IRQ_TX]);
	c_crc_err: cover property (ev[IRQ_CRC]);

endmodule // cbi_can_integ

/* verification/cbi_bus_node.sv */
// Far-side CAN node: wired-AND bus with the device, acknowledges frames.
// Assumes classical frames with no data bytes and a bench-set bit length.
module cbi_bus_node (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic tx_i,
	input wire logic dom_i,
	input wire logic ack_en_i,
	input wire logic [15:0] bit_clks_i,
	output logic rx_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic drv;
	logic busy;
	logic last;
	logic [15:0] cnt;
	logic [15:0] rc;
	logic [7:0] nb;
	logic [2:0] run;

	////////////////////////////////////////////////////////////////////////////////
	// Wired-AND of all drivers, 0 is dominant
	assign rx_o = tx_i & drv & !dom_i;

	// Frame tracker: destuffs up to CRC end, then drives the ACK slot
	always @(posedge clock_i)
	begin
		if (reset_i)
		begin
			busy <= 1'h0;
			drv <= 1'h1;
			rc <= 16'h0;
		end
		else
		begin
			rc <= rx_o ? rc + 16'h1 : 16'h0;
			if (!busy && !rx_o)
			begin
				busy <= 1'h1;
				cnt <= 16'h1;
				nb <= 8'h0;
				run <= 3'h0;
				last <= 1'h1;
			end
			else if (busy)
			begin
				cnt <= (cnt == bit_clks_i - 16'h1) ? 16'h0 : cnt + 16'h1;
				// Sample late in the bit; a sixth bit after five equal ones is a stuff bit
				if (cnt == (bit_clks_i >> 1) + (bit_clks_i >> 3))
				begin
					if (nb < 8'h21 && run == 3'h5)
						run <= 3'h1;
					else
					begin
						nb <= nb + 8'h1;
						run <= (rx_o == last) ? run + 3'h1 : 3'h1;
					end
					last <= rx_o;
				end
				if (cnt == 16'h0)
					drv <= !(nb == 8'h22 && ack_en_i);
				// Ten recessive bits mean the bus is idle again
				if (rc > bit_clks_i * 16'hA)
					busy <= 1'h0;
			end
		end
	end
endmodule // cbi_bus_node

/* verification/cbi_can_integ_test.sv */
// Self-checking bench of the CAN integration core, register bus and bus node.
// Assumes default bit timing of 4 clocks per quantum and 16 quanta per bit.
module cbi_can_integ_test import cbi_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock_i, reset_i, avs_read_i, avs_write_i, avs_waitrequest_o;
	logic can_rx_i, can_tx_o, irq_o, dom, ack_en;
	logic [5:0] avs_address_i;
	logic [3:0] avs_byteenable_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, seed, x;
	logic [15:0] bit_clks;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	int n_fail, tests_run, t;

	// Clock of 4 ns
	always #2 clock_i = ~clock_i;

	cbi_can_integ uut (.clock_i(clock_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .can_rx_i(can_rx_i), .can_tx_o(can_tx_o),
		.irq_o(irq_o));
	cbi_bus_node node (.clock_i(clock_i), .reset_i(reset_i), .tx_i(can_tx_o), .dom_i(dom),
		.ack_en_i(ack_en), .bit_clks_i(bit_clks), .rx_o(can_rx_i));

	////////////////////////////////////////////////////////////////////////////////
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task final_report();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task timeout();
		n_fail++;
		$display("unexpected wait expired");
		final_report();
	endtask

	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Avalon master: holds the request until waitrequest is sampled low
	task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int k;
		@(posedge clock_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		for (k = 0; k < 50; k++)
		begin
			@(posedge clock_i);
			if (avs_waitrequest_o === 1'h0)
				break;
		end
		if (k == 50)
			timeout();
		avs_write_i <= 1'h0;
		avs_read_i <= 1'h0;
	endtask

	task rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		bus(1'h0, a, 32'h0);
	endtask

	// Read monitor pairs each completed read with the oldest expectation
	always @(posedge clock_i)
		if (avs_read_i === 1'h1 && avs_waitrequest_o === 1'h0 && exp_q.size() > 0)
			check("read data", avs_readdata_o & msk_q.pop_front(), exp_q.pop_front());

	task wait_irq(output int c);
		for (c = 0; c < 20000 && irq_o !== 1'h1; c++)
			@(posedge clock_i);
		if (c == 20000)
			timeout();
	endtask

	// Halt, release, optional dominant spike, then mask and clear the event
	task integ(input logic ef, input int sp, output int c);
		bus(1'h1, OFS_CTRL, {30'h0, ef, 1'h1});
		rd(OFS_STATUS, 32'h0000_0001, 32'h0000_003F);
		check("halted tx", {31'h0, can_tx_o}, 32'h0000_0001);
		bus(1'h1, OFS_CTRL, {30'h0, ef, 1'h0});
		if (sp > 0)
			fork
				begin
					repeat (300) @(posedge clock_i);
					dom <= 1'h1;
					repeat (sp) @(posedge clock_i);
					dom <= 1'h0;
				end
			join_none
		rd(OFS_STATUS, 32'h0000_0002, 32'h0000_003F);
		wait_irq(c);
		rd(OFS_STATUS, 32'h0000_0004, 32'h0000_003F);
		bus(1'h1, OFS_IRQ_MASK, 32'h0000_0024);
		repeat (3) @(posedge clock_i);
		check("masked irq", {31'h0, irq_o}, 32'h0000_0000);
		rd(OFS_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
		bus(1'h1, OFS_IRQ_STAT, 32'h0000_0001);
		rd(OFS_IRQ_STAT, 32'h0000_0000, 32'h0000_0001);
		bus(1'h1, OFS_IRQ_MASK, 32'h0000_0025);
	endtask

	// Send one frame, with or without a partner that acknowledges it
	task tx(input logic [6:0] f, input logic ack);
		int c, k;
		bus(1'h1, OFS_TIMING, {9'h0, f, 16'h0B03});
		bit_clks <= 16'h4 * (16'hD + {9'h0, f});
		integ(1'h0, 0, c);
		x = xs();
		bus(1'h1, OFS_TX_ID, {16'h0, 4'h0, 1'h0, x[10:0] | 11'h400});
		bus(1'h1, OFS_TX_DATA, xs());
		ack_en <= ack;
		bus(1'h1, OFS_TX_REQ, 32'h0000_0001);
		for (k = 0; k < 500 && can_tx_o !== 1'h0; k++)
			@(posedge clock_i);
		if (k == 500)
			timeout();
		for (c = 0; c < 2000 && can_tx_o === 1'h0; c++)
			@(posedge clock_i);
		check("sof clocks", 32'(c), 32'(4 * (13 + f)));
		wait_irq(c);
		// Error flag, delimiter and two intermission bits pass, then a
		// dominant third intermission bit must start the pending retry
		if (!ack)
			fork
				begin
					repeat (17 * 4 * (13 + f) - 23) @(posedge clock_i);
					dom <= 1'h1;
					repeat (52) @(posedge clock_i);
					dom <= 1'h0;
				end
			join_none
		rd(OFS_IRQ_STAT, ack ? 32'h0000_0004 : 32'h0000_0020, 32'h0000_0024);
		if (!ack)
		begin
			ack_en <= 1'h1;
			bus(1'h1, OFS_IRQ_STAT, 32'h0000_0020);
			repeat (3) @(posedge clock_i);
			wait_irq(c);
			rd(OFS_IRQ_STAT, 32'h0000_0004, 32'h0000_0024);
		end
		rd(OFS_TX_REQ, 32'h0000_0000, 32'h0000_0001);
		bus(1'h1, OFS_IRQ_STAT, 32'h0000_0024);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		clock_i = 1'h0;
		reset_i = 1'h1;
		avs_read_i = 1'h0;
		avs_write_i = 1'h0;
		avs_address_i = 6'h0;
		avs_writedata_i = 32'h0;
		avs_byteenable_i = 4'hF;
		dom = 1'h0;
		ack_en = 1'h1;
		bit_clks = 16'h0040;
		seed = 32'h0000_000C;
		n_fail = 0;
		tests_run = 0;
		repeat (12) @(posedge clock_i);
		reset_i <= 1'h0;
		rd(OFS_CTRL, CTRL_RESET, 32'hFFFF_FFFF);
		rd(OFS_TIMING, TIMING_RESET, 32'hFFFF_FFFF);
		rd(6'h28, 32'h0000_0000, 32'hFFFF_FFFF);
		bus(1'h1, OFS_IRQ_MASK, 32'h0000_0025);
		integ(1'h1, 4, t);
		check("short spike", {31'h0, t < 800}, 32'h0000_0001);
		integ(1'h1, 64, t);
		check("long spike", {31'h0, t > 960}, 32'h0000_0001);
		tx(7'h3, 1'h0);
		tx(7'h1, 1'h1);
		final_report();
	end
endmodule // cbi_can_integ_test
